// ===== hw/lie_regs.vh
// constants of the logic io event processor
`ifndef LIE_REGS_VH
`define LIE_REGS_VH
// state word bit positions
`define LIE_BIT_TRUE   0
`define LIE_BIT_RISE   1
`define LIE_BIT_FALL   2
`define LIE_BIT_ACTIVE 3
`define LIE_BIT_PASS   4
`define LIE_BIT_FAIL   5
// logged event codes
`define LIE_CODE_RISE   6'h03
`define LIE_CODE_FALL   6'h04
`define LIE_CODE_ACTIVE 6'h09
`define LIE_CODE_PASS   6'h11
`define LIE_CODE_FAIL   6'h24
// a fall or turn-off is logged only after more than this many high samples
`define LIE_MIN_HIGH    16'h0002
// output modes
`define LIE_MODE_LEVEL  2'h0
`define LIE_MODE_SINGLE 2'h1
`define LIE_MODE_PULSE  2'h2
// reset values
`define LIE_RST_WORD    6'h00
`define LIE_RST_TS      32'h0000_0000
`endif

// ===== hw/lie_in_chan.v
// one input channel: debounce, duration test, state word
`timescale 1ns/1ps
`include "lie_regs.vh"
module lie_in_chan #(
  parameter CW = 16
) (
  input  wire          clock,
  input  wire          reset_n,
  input  wire          raw_in,
  input  wire          invert,
  input  wire [CW-1:0] debounce_len,
  input  wire          dur_en,
  input  wire [CW-1:0] active_len,
  input  wire [CW-1:0] pass_len,
  output reg  [5:0]    state_r,
  output reg  [CW-1:0] high_cnt_r
);
  // ==========================================================
  // debounce
  reg          level_r;
  reg [CW-1:0] stab_r;
  wire         samp = raw_in ^ invert;
  always @(posedge clock) begin
    if (!reset_n) begin
      level_r <= 1'b0;
      stab_r  <= {CW{1'b0}};
    end else if (debounce_len == {CW{1'b0}}) begin
      level_r <= samp;
      stab_r  <= {CW{1'b0}};
    end else if (samp == level_r) begin
      stab_r <= {CW{1'b0}};
    end else if (stab_r + 1'b1 >= debounce_len) begin
      level_r <= samp;
      stab_r  <= {CW{1'b0}};
    end else begin
      stab_r <= stab_r + 1'b1;
    end
  end
  // ==========================================================
  // duration test and state word
  reg prev_r;
  reg act_r;
  reg passed_r;
  wire rise = level_r & ~prev_r;
  wire fall = ~level_r & prev_r;
  wire [CW-1:0] held = rise ? {CW{1'b0}} : high_cnt_r;
  wire act_hit  = dur_en & level_r & ~act_r & (held + 1'b1 >= active_len);
  wire pass_hit = dur_en & level_r & act_r & ~passed_r &
                  (held + 1'b1 >= active_len + pass_len);
  always @(posedge clock) begin
    if (!reset_n) begin
      prev_r     <= 1'b0;
      act_r      <= 1'b0;
      passed_r   <= 1'b0;
      high_cnt_r <= {CW{1'b0}};
      state_r    <= `LIE_RST_WORD;
    end else begin
      prev_r <= level_r;
      if (level_r) begin
        if (high_cnt_r != {CW{1'b1}})
          high_cnt_r <= rise ? {{(CW-1){1'b0}}, 1'b1} : high_cnt_r + 1'b1;
      end
      if (act_hit)
        act_r <= 1'b1;
      if (pass_hit)
        passed_r <= 1'b1;
      if (fall) begin
        act_r    <= 1'b0;
        passed_r <= 1'b0;
      end
      state_r[`LIE_BIT_TRUE]   <= level_r;
      state_r[`LIE_BIT_RISE]   <= rise;
      state_r[`LIE_BIT_FALL]   <= fall;
      state_r[`LIE_BIT_ACTIVE] <= act_hit;
      state_r[`LIE_BIT_PASS]   <= pass_hit;
      state_r[`LIE_BIT_FAIL]   <= fall & act_r & ~passed_r;
    end
  end
endmodule // lie_in_chan

// ===== hw/lie_out_chan.v
// one output channel: level, single sample or timed pulse
`timescale 1ns/1ps
`include "lie_regs.vh"
module lie_out_chan #(
  parameter CW = 16
) (
  input  wire          clock,
  input  wire          reset_n,
  input  wire [1:0]    mode,
  input  wire          cmd_level,
  input  wire          cmd_trig,
  input  wire [CW-1:0] pulse_len,
  input  wire          invert,
  output reg           out_r,
  output reg           on_evt_r,
  output reg           off_evt_r
);
  reg          drive_r;
  reg [CW-1:0] left_r;
  reg [CW-1:0] high_r;
  reg          trig_d_r;
  wire         trig_edge = cmd_trig & ~trig_d_r;
  always @(posedge clock) begin
    if (!reset_n) begin
      drive_r  <= 1'b0;
      left_r   <= {CW{1'b0}};
      trig_d_r <= 1'b0;
    end else begin
      trig_d_r <= cmd_trig;
      case (mode)
        `LIE_MODE_LEVEL: begin
          drive_r <= cmd_level;
        end
        `LIE_MODE_SINGLE: begin
          drive_r <= trig_edge;
        end
        `LIE_MODE_PULSE: begin
          if (trig_edge) begin
            drive_r <= 1'b1;
            left_r  <= pulse_len;
          end else if (left_r != {CW{1'b0}}) begin
            left_r <= left_r - 1'b1;
          end else begin
            drive_r <= 1'b0;
          end
        end
        default: begin
          drive_r <= 1'b0;
        end
      endcase
    end
  end
  always @(posedge clock) begin
    if (!reset_n) begin
      out_r     <= 1'b0;
      high_r    <= {CW{1'b0}};
      on_evt_r  <= 1'b0;
      off_evt_r <= 1'b0;
    end else begin
      out_r    <= drive_r ^ invert;
      on_evt_r <= drive_r & ~(out_r ^ invert);
      off_evt_r <= ~drive_r & (out_r ^ invert) &
                   (high_r > `LIE_MIN_HIGH);
      if (drive_r)
        high_r <= (out_r ^ invert) ?
                  ((high_r == {CW{1'b1}}) ? high_r : high_r + 1'b1) :
                  {{(CW-1){1'b0}}, 1'b1};
    end
  end
endmodule // lie_out_chan

// ===== hw/lie_top.v
// logic io event processor: inputs, outputs, event log, packers
`timescale 1ns/1ps
`include "lie_regs.vh"
module lie_top #(
  parameter NI = 4,
  parameter NO = 4,
  parameter CW = 16
) (
  input  wire             clock,
  input  wire             reset_n,
  input  wire [NI-1:0]    raw_in,
  input  wire [NI-1:0]    in_invert,
  input  wire [CW-1:0]    debounce_len,
  input  wire             dur_en,
  input  wire [CW-1:0]    active_len,
  input  wire [CW-1:0]    pass_len,
  input  wire             in_log_en,
  input  wire             result_link_en,
  input  wire [2:0]       result_bit_sel,
  input  wire [1:0]       result_chan_sel,
  input  wire [2*NO-1:0]  out_mode,
  input  wire [NO-1:0]    out_invert,
  input  wire [CW-1:0]    pulse_length_param,
  input  wire [NO-1:0]    out_link,
  input  wire [NO-1:0]    output_drive_param,
  input  wire [NO-1:0]    manual_click,
  input  wire [NO-1:0]    output_pack_param,
  input  wire             output_pack_wr,
  input  wire [NO-1:0]    raw_output_unpacker,
  input  wire             unpacker_en,
  input  wire             out_log_en,
  output reg  [6*NI-1:0]  input_state_word_param,
  output reg  [NI-1:0]    raw_input_packer,
  output reg              result_bit_r,
  output reg  [5:0]       result_word_r,
  output reg              in_evt_valid_r,
  output reg  [1:0]       in_evt_chan_r,
  output reg  [5:0]       in_evt_code_r,
  output reg  [31:0]      in_evt_ts_r,
  output reg  [NO-1:0]    out_pins_r,
  output reg              out_evt_valid_r,
  output reg  [1:0]       out_evt_chan_r,
  output reg              out_evt_on_r,
  output reg  [31:0]      out_evt_ts_r
);
  // ==========================================================
  // timestamp
  reg [31:0] ts_r;
  always @(posedge clock) begin
    if (!reset_n)
      ts_r <= `LIE_RST_TS;
    else
      ts_r <= ts_r + 32'h0000_0001;
  end
  // ==========================================================
  // input channels, their event codes and the pick chain
  wire [6*NI-1:0]  st;
  wire [CW*NI-1:0] hc;
  wire [NI-1:0]    ch_v;
  wire [6*NI-1:0]  ch_code;
  wire [NI:0]      ip_v;
  wire [2*NI+1:0]  ip_c;
  wire [6*NI+5:0]  ip_code;
  assign ip_v[NI]           = 1'b0;
  assign ip_c[2*NI +: 2]    = 2'h0;
  assign ip_code[6*NI +: 6] = 6'h00;
  genvar gi;
  generate
    for (gi = 0; gi < NI; gi = gi + 1) begin : g_in
      wire [31:0] num_w  = gi;
      wire [5:0]  s_w    = st[6*gi +: 6];
      wire        long_w = (hc[CW*gi +: CW] > `LIE_MIN_HIGH);
      lie_in_chan #(.CW(CW)) u_in (
        .clock        (clock),
        .reset_n      (reset_n),
        .raw_in       (raw_in[gi]),
        .invert       (in_invert[gi]),
        .debounce_len (debounce_len),
        .dur_en       (dur_en),
        .active_len   (active_len),
        .pass_len     (pass_len),
        .state_r      (st[6*gi +: 6]),
        .high_cnt_r   (hc[CW*gi +: CW])
      );
      // a fall counts only after a long enough high run
      assign ch_v[gi] = s_w[`LIE_BIT_RISE] | s_w[`LIE_BIT_ACTIVE] |
                        s_w[`LIE_BIT_PASS] | s_w[`LIE_BIT_FAIL] |
                        (s_w[`LIE_BIT_FALL] & long_w);
      // one code per cycle: fail, fall, pass, active, rise
      assign ch_code[6*gi +: 6] =
        s_w[`LIE_BIT_FAIL]   ? `LIE_CODE_FAIL   :
        s_w[`LIE_BIT_FALL]   ? `LIE_CODE_FALL   :
        s_w[`LIE_BIT_PASS]   ? `LIE_CODE_PASS   :
        s_w[`LIE_BIT_ACTIVE] ? `LIE_CODE_ACTIVE :
                               `LIE_CODE_RISE;
      // lowest channel wins, others dropped
      assign ip_v[gi] = ch_v[gi] | ip_v[gi+1];
      assign ip_c[2*gi +: 2] = ch_v[gi] ? num_w[1:0] :
                               ip_c[2*gi+2 +: 2];
      assign ip_code[6*gi +: 6] = ch_v[gi] ? ch_code[6*gi +: 6] :
                                  ip_code[6*gi+6 +: 6];
    end
  endgenerate
  wire       ie_v    = ip_v[0];
  wire [1:0] ie_c    = ip_c[1:0];
  wire [5:0] ie_code = ip_code[5:0];
  // result link: bit selects above five read as zero
  wire [5:0] sel_word = st[6*result_chan_sel +: 6];
  wire [7:0] sel_ext  = {2'b00, sel_word};
  always @(posedge clock) begin
    if (!reset_n) begin
      in_evt_valid_r         <= 1'b0;
      in_evt_chan_r          <= 2'h0;
      in_evt_code_r          <= 6'h00;
      in_evt_ts_r            <= `LIE_RST_TS;
      input_state_word_param <= {6*NI{1'b0}};
      raw_input_packer       <= {NI{1'b0}};
      result_bit_r           <= 1'b0;
      result_word_r          <= `LIE_RST_WORD;
    end else begin
      in_evt_valid_r <= in_log_en & ie_v;
      if (ie_v) begin
        in_evt_chan_r <= ie_c;
        in_evt_code_r <= ie_code;
        in_evt_ts_r   <= ts_r;
      end
      input_state_word_param <= st;
      raw_input_packer       <= raw_in;
      if (result_link_en) begin
        result_word_r <= sel_word;
        result_bit_r  <= sel_ext[result_bit_sel];
      end else begin
        result_word_r <= `LIE_RST_WORD;
        result_bit_r  <= 1'b0;
      end
    end
  end
  // ==========================================================
  // output command sources
  reg  [NO-1:0] word_r;
  always @(posedge clock) begin
    if (!reset_n)
      word_r <= {NO{1'b0}};
    else if (output_pack_wr)
      word_r <= output_pack_param;
  end
  wire [NO-1:0] cmd = out_link | output_drive_param | manual_click |
                      word_r | (unpacker_en ? raw_output_unpacker :
                      {NO{1'b0}});
  // ==========================================================
  // output channels and their event pick chain
  wire [NO-1:0]   pin;
  wire [NO-1:0]   on_e;
  wire [NO-1:0]   off_e;
  wire [NO:0]     op_v;
  wire [2*NO+1:0] op_c;
  wire [NO:0]     op_on;
  assign op_v[NO]        = 1'b0;
  assign op_c[2*NO +: 2] = 2'h0;
  assign op_on[NO]       = 1'b0;
  genvar go;
  generate
    for (go = 0; go < NO; go = go + 1) begin : g_out
      wire [31:0] num_w = go;
      wire        any_w = on_e[go] | off_e[go];
      lie_out_chan #(.CW(CW)) u_out (
        .clock     (clock),
        .reset_n   (reset_n),
        .mode      (out_mode[2*go +: 2]),
        .cmd_level (cmd[go]),
        .cmd_trig  (cmd[go]),
        .pulse_len (pulse_length_param),
        .invert    (out_invert[go]),
        .out_r     (pin[go]),
        .on_evt_r  (on_e[go]),
        .off_evt_r (off_e[go])
      );
      // lowest channel wins, others dropped
      assign op_v[go] = any_w | op_v[go+1];
      assign op_c[2*go +: 2] = any_w ? num_w[1:0] : op_c[2*go+2 +: 2];
      assign op_on[go] = any_w ? on_e[go] : op_on[go+1];
    end
  endgenerate
  wire       oe_v  = op_v[0];
  wire [1:0] oe_c  = op_c[1:0];
  wire       oe_on = op_on[0];
  always @(posedge clock) begin
    if (!reset_n) begin
      out_pins_r      <= {NO{1'b0}};
      out_evt_valid_r <= 1'b0;
      out_evt_chan_r  <= 2'h0;
      out_evt_on_r    <= 1'b0;
      out_evt_ts_r    <= `LIE_RST_TS;
    end else begin
      out_pins_r      <= pin;
      out_evt_valid_r <= out_log_en & oe_v;
      if (oe_v) begin
        out_evt_chan_r <= oe_c;
        out_evt_on_r   <= oe_on;
        out_evt_ts_r   <= ts_r;
      end
    end
  end
endmodule // lie_top

// ===== sim/lie_top_asserts.sv
// checker on the ports of the event processor top
`timescale 1ns/1ps
module lie_top_asserts #(
  parameter NI = 4,
  parameter NO = 4,
  parameter CW = 16
) (
  input wire          clock,
  input wire          reset_n,
  input wire [NI-1:0] raw_in,
  input wire [NI-1:0] in_invert,
  input wire [CW-1:0] debounce_len,
  input wire          in_log_en,
  input wire [2*NO-1:0] out_mode,
  input wire [NO-1:0] out_invert,
  input wire [CW-1:0] pulse_length_param,
  input wire [NO-1:0] output_drive_param,
  input wire          out_log_en,
  input wire [NI-1:0] raw_input_packer,
  input wire          in_evt_valid_r,
  input wire [1:0]    in_evt_chan_r,
  input wire [5:0]    in_evt_code_r,
  input wire [NO-1:0] out_pins_r,
  input wire          out_evt_valid_r,
  input wire [1:0]    out_evt_chan_r,
  input wire          out_evt_on_r
);
  // ==========================================
  // helper: length of the high run on output 0
  reg [CW:0] hi_r;
  always @(posedge clock) begin
    if (!reset_n || !out_pins_r[0])
      hi_r <= {(CW+1){1'b0}};
    else
      hi_r <= hi_r + 1'b1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence s_press0;
    $rose(raw_in[0]) && debounce_len == 16'h0 && !in_invert[0] && in_log_en;
  endsequence
  sequence s_rise0;
    in_evt_valid_r && in_evt_chan_r == 2'h0 && in_evt_code_r == 6'h03;
  endsequence
  sequence s_on0;
    out_evt_valid_r && out_evt_on_r && out_evt_chan_r == 2'h0;
  endsequence
  // ==========================================
  // assertions
  a_rise_logs: assert property (s_press0 |-> ##3 s_rise0)
    else $error("rise not logged");
  a_evt_codes: assert property (in_evt_valid_r |->
    in_evt_code_r inside {6'h03, 6'h04, 6'h09, 6'h11, 6'h24})
    else $error("bad event code");
  a_raw_pack: assert property ($stable(raw_in) [*3] |->
    raw_input_packer == raw_in) else $error("raw word wrong");
  a_level_follow: assert property ($rose(output_drive_param[0]) &&
    out_mode[1:0] == 2'h0 && !out_invert[0] |-> ##3 out_pins_r[0])
    else $error("level not followed");
  a_pulse_width: assert property ($fell(out_pins_r[0]) &&
    out_mode[1:0] == 2'h2 && !out_invert[0] |->
    hi_r == pulse_length_param + 1'b1) else $error("pulse width");
  a_single_width: assert property ($rose(out_pins_r[0]) &&
    out_mode[1:0] == 2'h1 && !out_invert[0] |=> !out_pins_r[0])
    else $error("single sample too long");
  a_on_logged: assert property ($rose(out_pins_r[0]) &&
    out_log_en && !out_invert[0] |-> ##[0:2] s_on0)
    else $error("on not logged");
  a_off_short: assert property ($rose(out_pins_r[0]) &&
    out_mode[1:0] == 2'h1 && out_log_en && !out_invert[0] |->
    (!(out_evt_valid_r && !out_evt_on_r && out_evt_chan_r == 2'h0)) [*4])
    else $error("short high logged off");
endmodule // lie_top_asserts
bind lie_top lie_top_asserts #(.NI(NI), .NO(NO), .CW(CW)) chk (
  .clock              (clock),
  .reset_n            (reset_n),
  .raw_in             (raw_in),
  .in_invert          (in_invert),
  .debounce_len       (debounce_len),
  .in_log_en          (in_log_en),
  .out_mode           (out_mode),
  .out_invert         (out_invert),
  .pulse_length_param (pulse_length_param),
  .output_drive_param (output_drive_param),
  .out_log_en         (out_log_en),
  .raw_input_packer   (raw_input_packer),
  .in_evt_valid_r     (in_evt_valid_r),
  .in_evt_chan_r      (in_evt_chan_r),
  .in_evt_code_r      (in_evt_code_r),
  .out_pins_r         (out_pins_r),
  .out_evt_valid_r    (out_evt_valid_r),
  .out_evt_chan_r     (out_evt_chan_r),
  .out_evt_on_r       (out_evt_on_r)
);

// ===== sim/lie_ttl_model.sv
// model of the ttl lines feeding the inputs
`timescale 1ns/1ps
module lie_ttl_model (
  input  wire        clock,
  input  wire        go,
  input  wire [15:0] len,
  input  wire        bounce,
  input  wire [3:1]  hold,
  output wire [3:0]  raw_in
);
  reg [15:0] cnt_r = 16'h0;
  // bouncing contact opens every other pair of samples
  assign raw_in = {hold, cnt_r != 16'h0 && (!bounce || cnt_r[1])};
  always @(posedge clock) begin
    if (go)
      cnt_r <= len;
    else if (cnt_r != 16'h0)
      cnt_r <= cnt_r - 16'h1;
  end
endmodule // lie_ttl_model

// ===== sim/tb_top.sv
// testbench of the logic io event processor
`timescale 1ns/1ps
`include "lie_regs.vh"
module tb_top;
  logic clock;
  logic reset_n = 1'b0, dur_en = 1'b0, in_log_en = 1'b0, rl_en = 1'b0;
  logic pack_wr = 1'b0, unp_en = 1'b0, out_log_en = 1'b0, go = 1'b0;
  logic bounce = 1'b0;
  logic [3:0] in_inv = 4'h0, out_inv = 4'h0, link = 4'h0, drive = 4'h0;
  logic [3:0] click = 4'h0, pack = 4'h0, unp = 4'h0;
  logic [15:0] deb = 16'h0, act = 16'h0, pas = 16'h0, plen = 16'h0;
  logic [15:0] len = 16'h0;
  logic [1:0] csel = 2'h0;
  logic [2:0] bsel = 3'h0;
  logic [7:0] mode = 8'h0;
  logic [3:1] hold = 3'h0;
  wire [23:0] isw;
  wire [3:0]  raw, rip, pins;
  wire        rb, iv, ov, oon;
  wire [5:0]  rw, icode;
  wire [1:0]  ich, och;
  wire [31:0] its, ots;
  int err_count = 0, total_checks = 0, hi0, on0, off0;
  logic [5:0] cq[$];
  logic [31:0] tq[$];
  logic [31:0] on_ts, off_ts;
  lie_ttl_model ttl (.clock(clock), .go(go), .len(len), .bounce(bounce),
    .hold(hold), .raw_in(raw));
  lie_top uut (.clock(clock), .reset_n(reset_n), .raw_in(raw),
    .in_invert(in_inv), .debounce_len(deb), .dur_en(dur_en),
    .active_len(act), .pass_len(pas), .in_log_en(in_log_en),
    .result_link_en(rl_en), .result_bit_sel(bsel), .result_chan_sel(csel),
    .out_mode(mode), .out_invert(out_inv), .pulse_length_param(plen),
    .out_link(link), .output_drive_param(drive), .manual_click(click),
    .output_pack_param(pack), .output_pack_wr(pack_wr),
    .raw_output_unpacker(unp), .unpacker_en(unp_en), .out_log_en(out_log_en),
    .input_state_word_param(isw), .raw_input_packer(rip),
    .result_bit_r(rb), .result_word_r(rw), .in_evt_valid_r(iv),
    .in_evt_chan_r(ich), .in_evt_code_r(icode), .in_evt_ts_r(its),
    .out_pins_r(pins), .out_evt_valid_r(ov), .out_evt_chan_r(och),
    .out_evt_on_r(oon), .out_evt_ts_r(ots));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // ==========================================
  // collectors for channel 0 events and output 0 high time
  always @(posedge clock) begin
    if (iv === 1'b1 && ich === 2'h0) begin
      cq.push_back(icode);
      tq.push_back(its);
    end
    if (pins[0] === 1'b1)
      hi0++;
    if (ov === 1'b1 && och === 2'h0) begin
      on0 += (oon === 1'b1);
      off0 += (oon === 1'b0);
      if (oon === 1'b1)
        on_ts = ots;
      else
        off_ts = ots;
    end
  end
  // ==========================================
  // tasks
  task chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task tally_and_finish();
    if (err_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task press(input logic [15:0] n, input logic b, input logic [23:0] e,
             input int k);
    cq.delete();
    tq.delete();
    len = n;
    bounce = b;
    go = 1'b1;
    @(negedge clock);
    go = 1'b0;
    repeat (n + 16'h14) @(negedge clock);
    chk(cq.size() == k, "event count");
    for (int i = 0; i < k && i < cq.size(); i++)
      chk(cq[i] === e[6*i +: 6], "event code");
    if (k > 1 && cq.size() == k)
      chk(tq[k-1] - tq[0] === {16'h0, n}, "event time");
  endtask
  task otest(input logic [1:0] m, input logic [15:0] l, input int src,
             input int h, input int f);
    int i;
    mode[1:0] = m;
    plen = l;
    hi0 = 0;
    on0 = 0;
    off0 = 0;
    case (src)
      0: link[0] = 1'b1;
      1: drive[0] = 1'b1;
      default: click[0] = 1'b1;
    endcase
    for (i = 0; i < 8 && pins[0] !== 1'b1; i++)
      @(negedge clock);
    if (i == 8) begin
      chk(1'b0, "output timeout");
      tally_and_finish();
    end
    repeat (2) @(negedge clock);
    link[0] = 1'b0;
    drive[0] = 1'b0;
    click[0] = 1'b0;
    repeat (15) @(negedge clock);
    chk(hi0 == (m == 2'h0 ? i + 2 : h), "high time");
    chk(on0 == 1, "on log");
    chk(off0 == f, "off log");
    if (f == 1)
      chk(off_ts - on_ts === (m == 2'h0 ? i + 2 : h), "off time");
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (12) @(negedge clock);
    reset_n = 1'b1;
    @(negedge clock);
    chk(pins === 4'h0 && isw === 24'h0 && iv === 1'b0, "reset value");
    in_log_en = 1'b1;
    out_log_en = 1'b1;
    dur_en = 1'b1;
    act = 16'h5;
    pas = 16'h5;
    press(16'h2, 1'b0, `LIE_CODE_RISE, 1);
    press(16'h4, 1'b0, {`LIE_CODE_FALL, `LIE_CODE_RISE}, 2);
    press(16'h7, 1'b0, {`LIE_CODE_FAIL, `LIE_CODE_ACTIVE,
      `LIE_CODE_RISE}, 3);
    press(16'hF, 1'b0, {`LIE_CODE_FALL, `LIE_CODE_PASS, `LIE_CODE_ACTIVE,
      `LIE_CODE_RISE}, 4);
    dur_en = 1'b0;
    deb = 16'h4;
    press(16'hA, 1'b1, 24'h0, 0);
    press(16'hA, 1'b0, {`LIE_CODE_FALL, `LIE_CODE_RISE}, 2);
    in_log_en = 1'b0;
    press(16'h5, 1'b0, 24'h0, 0);
    in_log_en = 1'b1;
    deb = 16'h0;
    hold = 3'h1;
    in_inv = 4'h4;
    rl_en = 1'b1;
    csel = 2'h1;
    repeat (8) @(negedge clock);
    chk(rip === 4'h2 && isw[6] === 1'b1 && isw[12] === 1'b1, "in word");
    chk(rb === 1'b1 && rw === 6'h01, "result link");
    otest(2'h0, 16'h0, 1, 0, 1);
    otest(2'h1, 16'h0, 2, 1, 0);
    otest(2'h2, 16'h0, 0, 1, 0);
    otest(2'h2, 16'h5, 0, 6, 1);
    mode = 8'h0;
    pack = 4'hA;
    pack_wr = 1'b1;
    @(negedge clock);
    pack_wr = 1'b0;
    repeat (5) @(negedge clock);
    chk(pins === 4'hA, "pack word");
    pack = 4'h0;
    pack_wr = 1'b1;
    @(negedge clock);
    pack_wr = 1'b0;
    unp = 4'h5;
    unp_en = 1'b1;
    repeat (5) @(negedge clock);
    chk(pins === 4'h5, "unpacker word");
    unp_en = 1'b0;
    out_inv = 4'h8;
    repeat (5) @(negedge clock);
    chk(pins === 4'h8, "inverted idle");
    tally_and_finish();
  end
endmodule // tb_top
